/* src/cip_cpu_interrupt_prioritizer.v */
// interrupt recognition, priority and restart vectoring of an 8-bit processor
//
// The Avalon-MM interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
`include "cip_map.vh"

// Summary of operation
// - accept trap first, then edge, mid, low restart, bus-vectored request last
// - bus-vectored request obeys enable flag; its restart opcode comes from data bus
// - bus-vectored restart targets are 0, 8, 16 ... 56, eight bytes apart
// - push the program counter before branching to the vector
// - each of three restart inputs has a mask bit; trap has none
// - maskable restart fires only when enabled and its mask is clear
// - trap fires regardless of enable flag and masks
// - low and mid restart inputs are active-high levels sampled like bus request
// - rising edge on edge restart input sets a request flip-flop
// - edge request flip-flop stays set until serviced, then clears
// - edge request also clears by set-mask command or reset
// - edge request sets even while its mask is set
// - masks change only by set-mask command or reset
// - priority ignores which service routine runs now
// - hold request and all interrupt inputs are synchronised before use
// - trap is edge and level sensitive; re-armed only after going low
// - servicing any interrupt clears the global enable
// - trap saves prior enable; first read-mask returns it, later reads current
module cip_cpu_interrupt_prioritizer (
    input wire clk,
    input wire sys_rst,
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output wire avs_waitrequest,
    input wire trapRequest,
    input wire restart75Request,
    input wire restart65Request,
    input wire restart55Request,
    input wire bus_vectored_request,
    input wire holdRequest,
    input wire [7:0] dataBus,
    output reg vector_acknowledge_strobe,
    output reg holdSync,
    output reg pushPc,
    output reg branchValid,
    output reg [15:0] branchAddress,
    output reg [2:0] acceptedSource
);

    // ==============================================================
    // state of the acceptance sequence
    localparam ST_IDLE = 2'h0;
    localparam ST_ACK = 2'h1;
    localparam ST_PUSH = 2'h2;
    localparam ST_BRANCH = 2'h3;

    reg [1:0] state;
    reg [1:0] next_state;
    reg [4:0] syncFirst;
    reg [4:0] syncSecond;
    reg holdFirst;
    reg r75Last;
    reg r75Pending;
    reg trapLast;
    reg trapArmed;
    reg [2:0] mask;
    reg intEnable;
    reg savedEnable;
    reg savedValid;
    reg [2:0] pickedSource;
    reg [15:0] pickedVector;
    reg [7:0] opcodeLatch;
    reg ackDone;

    wire trapSync = syncSecond[4];
    wire r75Sync = syncSecond[3];
    wire r65Sync = syncSecond[2];
    wire r55Sync = syncSecond[1];
    wire vecReqSync = syncSecond[0];

    // bus decode
    wire wrCtrl = avs_write && (avs_address == `CIP_ADDR_CTRL) && avs_byteenable[0];
    wire wrMask = avs_write && (avs_address == `CIP_ADDR_MASK) && avs_byteenable[0];
    wire rdStatus = avs_read && (avs_address == `CIP_ADDR_STATUS);
    wire boundary = wrCtrl && avs_writedata[`CIP_CTRL_BOUNDARY];
    wire maskEnable = wrMask && avs_writedata[`CIP_MASK_MSE];

    // ==============================================================
    // reads take one wait state: the data register loads in the first cycle
    // and stands while waitrequest is low; writes finish in their first cycle
    reg rdAck;
    assign avs_waitrequest = avs_read && !rdAck;

    // rdAck marks the second, completing cycle of a read
    always @(posedge clk) begin
        if (sys_rst) begin
            rdAck <= 1'b0;
        end else begin
            rdAck <= avs_read && !rdAck;
        end
    end

    // ==============================================================
    // two-stage synchronisers for every request and for hold
    always @(posedge clk) begin
        if (sys_rst) begin
            // edge input idles high: start its stages high so reset makes no false edge
            syncFirst <= 5'h08;
            syncSecond <= 5'h08;
            holdFirst <= 1'b0;
            holdSync <= 1'b0;
        end else begin
            syncFirst <= {trapRequest, restart75Request, restart65Request,
                          restart55Request, bus_vectored_request};
            syncSecond <= syncFirst;
            holdFirst <= holdRequest;
            holdSync <= holdFirst;
        end
    end

    // ==============================================================
    // eligibility and fixed priority selection
    wire trapLive = trapSync && trapArmed;
    wire r75Live = intEnable && !mask[2] && r75Pending;
    wire r65Live = intEnable && !mask[1] && r65Sync;
    wire r55Live = intEnable && !mask[0] && r55Sync;
    wire vecReqLive = intEnable && vecReqSync;
    wire serviceNow = (state == ST_IDLE) && boundary;

    always @* begin
        // no notion of the running routine enters the choice
        pickedSource = `CIP_SRC_NONE;
        pickedVector = 16'h0000;
        if (trapLive) begin
            pickedSource = `CIP_SRC_TRAP;
            pickedVector = `CIP_VEC_TRAP;
        end else if (r75Live) begin
            pickedSource = `CIP_SRC_R75;
            pickedVector = `CIP_VEC_R75;
        end else if (r65Live) begin
            pickedSource = `CIP_SRC_R65;
            pickedVector = `CIP_VEC_R65;
        end else if (r55Live) begin
            pickedSource = `CIP_SRC_R55;
            pickedVector = `CIP_VEC_R55;
        end else if (vecReqLive) begin
            pickedSource = `CIP_SRC_BUS;
            pickedVector = 16'h0000;
        end
    end

    wire accepting = serviceNow && (pickedSource != `CIP_SRC_NONE);
    wire trapTaken = accepting && (pickedSource == `CIP_SRC_TRAP);
    wire r75Taken = accepting && (pickedSource == `CIP_SRC_R75);

    // ==============================================================
    // edge request flip-flop and trap re-arm
    always @(posedge clk) begin
        if (sys_rst) begin
            r75Last <= 1'b1;
            r75Pending <= 1'b0;
            trapLast <= 1'b0;
            trapArmed <= 1'b1;
        end else begin
            r75Last <= r75Sync;
            trapLast <= trapSync;
            // a new edge wins over any clear in the same cycle
            if (r75Sync && !r75Last) begin
                r75Pending <= 1'b1;
            end else if (r75Taken) begin
                r75Pending <= 1'b0;
            end else if (wrMask && avs_writedata[`CIP_MASK_R75]) begin
                r75Pending <= 1'b0;
            end
            // trap re-arms only after it is seen low
            if (!trapSync) begin
                trapArmed <= 1'b1;
            end else if (trapTaken) begin
                trapArmed <= 1'b0;
            end
            // an edge taken at once is the request just served, not a new one
            if (trapSync && !trapLast && !trapTaken) begin
                trapArmed <= 1'b1;
            end
        end
    end

    // ==============================================================
    // masks, global enable and saved enable
    always @(posedge clk) begin
        if (sys_rst) begin
            mask <= `CIP_MASK_RESET;
            intEnable <= 1'b0;
            savedEnable <= 1'b0;
            savedValid <= 1'b0;
        end else begin
            if (maskEnable) begin
                mask <= avs_writedata[2:0];
            end
            if (accepting) begin
                intEnable <= 1'b0;
            end else if (wrCtrl && avs_writedata[`CIP_CTRL_ENABLE]) begin
                intEnable <= 1'b1;
            end else if (wrCtrl && avs_writedata[`CIP_CTRL_DISABLE]) begin
                intEnable <= 1'b0;
            end
            if (trapTaken) begin
                savedEnable <= intEnable;
                savedValid <= 1'b1;
            end else if (rdStatus) begin
                savedValid <= 1'b0;
            end
        end
    end

    // ==============================================================
    // sequence: acknowledge (bus request only), push, branch
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (accepting && pickedSource == `CIP_SRC_BUS) begin
                    next_state = ST_ACK;
                end else if (accepting) begin
                    next_state = ST_PUSH;
                end
            end
            ST_ACK: begin
                if (ackDone) begin
                    next_state = ST_PUSH;
                end
            end
            ST_PUSH: next_state = ST_BRANCH;
            ST_BRANCH: next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            state <= ST_IDLE;
            vector_acknowledge_strobe <= 1'b0;
            ackDone <= 1'b0;
            opcodeLatch <= 8'h00;
            pushPc <= 1'b0;
            branchValid <= 1'b0;
            branchAddress <= 16'h0000;
            acceptedSource <= `CIP_SRC_NONE;
        end else begin
            state <= next_state;
            pushPc <= 1'b0;
            branchValid <= 1'b0;
            ackDone <= 1'b0;
            vector_acknowledge_strobe <= 1'b0;
            if (accepting) begin
                acceptedSource <= pickedSource;
                branchAddress <= pickedVector;
            end
            if (next_state == ST_ACK && !ackDone) begin
                vector_acknowledge_strobe <= (state == ST_IDLE);
            end
            if (state == ST_ACK && !ackDone) begin
                // opcode sampled at the edge that ends the strobe cycle
                opcodeLatch <= dataBus;
                ackDone <= 1'b1;
            end
            if (state == ST_PUSH) begin
                pushPc <= 1'b1;
                if (acceptedSource == `CIP_SRC_BUS) begin
                    // restart opcode field nnn gives vector nnn*8
                    branchAddress <= {10'h000, opcodeLatch[5:3], 3'h0};
                end
            end
            if (state == ST_BRANCH) begin
                branchValid <= 1'b1;
            end
        end
    end

    // ==============================================================
    // register read data
    always @(posedge clk) begin
        if (sys_rst) begin
            avs_readdata <= 32'h00000000;
        end else if (avs_read && !rdAck) begin
            // loaded once, in the first cycle, so the value holds for the master
            case (avs_address)
                `CIP_ADDR_MASK: avs_readdata <= {29'h0, mask};
                `CIP_ADDR_STATUS: begin
                    avs_readdata <= {23'h0, vecReqSync, trapSync, r75Pending, r65Sync,
                                     r55Sync, savedValid ? savedEnable : intEnable,
                                     mask};
                end
                `CIP_ADDR_ACCEPT: avs_readdata <= {13'h0, acceptedSource, branchAddress};
                default: avs_readdata <= 32'h00000000;
            endcase
        end
    end

endmodule

/* include/cip_map.vh */
// constants of the cpu interrupt prioritizer: register map, fields, source codes, vectors
`ifndef CIP_MAP_VH
`define CIP_MAP_VH
// ==============================================================
// register byte addresses
`define CIP_ADDR_CTRL 4'h0
`define CIP_ADDR_MASK 4'h4
`define CIP_ADDR_STATUS 4'h8
`define CIP_ADDR_ACCEPT 4'hC
// ==============================================================
// control register fields (write only command bits)
`define CIP_CTRL_ENABLE 0
`define CIP_CTRL_DISABLE 1
`define CIP_CTRL_BOUNDARY 2
// mask register fields (set-mask command layout)
`define CIP_MASK_M55 0
`define CIP_MASK_M65 1
`define CIP_MASK_M75 2
`define CIP_MASK_MSE 3
`define CIP_MASK_R75 4
// status register fields (read-mask command layout)
`define CIP_STAT_IE 3
`define CIP_STAT_P55 4
`define CIP_STAT_P65 5
`define CIP_STAT_P75 6
`define CIP_STAT_TRAP 7
`define CIP_STAT_BUS 8
// ==============================================================
// accepted source codes
`define CIP_SRC_NONE 3'h0
`define CIP_SRC_TRAP 3'h1
`define CIP_SRC_R75 3'h2
`define CIP_SRC_R65 3'h3
`define CIP_SRC_R55 3'h4
`define CIP_SRC_BUS 3'h5
// restart vector addresses
`define CIP_VEC_TRAP 16'h0024
`define CIP_VEC_R75 16'h003C
`define CIP_VEC_R65 16'h0034
`define CIP_VEC_R55 16'h002C
// restart call opcode layout: 11nnn111
`define CIP_RST_OPC_MASK 8'hC7
`define CIP_RST_OPC_BASE 8'hC7
// ==============================================================
// reset values
`define CIP_MASK_RESET 3'h7
`endif

/* test/cip_prioritizer_sva.sv */
// port checker of the interrupt prioritizer
`timescale 1ns/1ps
`include "cip_map.vh"
module cip_prioritizer_sva (
    input wire clk,
    input wire sys_rst,
    input wire [3:0] avs_address,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    input wire holdRequest,
    input wire holdSync,
    input wire [7:0] dataBus,
    input wire vector_acknowledge_strobe,
    input wire pushPc,
    input wire branchValid,
    input wire [15:0] branchAddress,
    input wire [2:0] acceptedSource
);
    reg [2:0] opLatch;
    reg bnd;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // ====================
    // opcode field at acknowledge, boundary write of last edge
    always @(posedge clk) begin
        if (vector_acknowledge_strobe) begin
            opLatch <= dataBus[5:3];
        end
        bnd <= !sys_rst && avs_write && avs_address == `CIP_ADDR_CTRL
            && avs_writedata[`CIP_CTRL_BOUNDARY] && avs_byteenable[0];
    end
    // restart target of each internal source
    function [15:0] vecOf(input [2:0] c);
        case (c)
            `CIP_SRC_TRAP: vecOf = `CIP_VEC_TRAP;
            `CIP_SRC_R75: vecOf = `CIP_VEC_R75;
            `CIP_SRC_R65: vecOf = `CIP_VEC_R65;
            default: vecOf = `CIP_VEC_R55;
        endcase
    endfunction
    // ====================
    a_push_then_branch: assert property (pushPc |=> branchValid)
        else $error("branch did not follow push");
    a_branch_after_push: assert property (branchValid |-> $past(pushPc))
        else $error("branch without push");
    a_strobe_to_push: assert property (vector_acknowledge_strobe |-> ##3 (pushPc
        && acceptedSource == `CIP_SRC_BUS)) else $error("no push after acknowledge");
    a_restart_vector: assert property (branchValid && acceptedSource != `CIP_SRC_BUS
        |-> branchAddress == vecOf(acceptedSource)) else $error("bad restart target");
    a_bus_vector: assert property (branchValid && acceptedSource == `CIP_SRC_BUS
        |-> branchAddress == {10'h000, opLatch, 3'h0}) else $error("bad vectored target");
    a_push_single: assert property (pushPc |=> !pushPc [*3])
        else $error("push repeated");
    a_boundary_cause: assert property ((pushPc && acceptedSource != `CIP_SRC_BUS)
        |-> $past(bnd)) else $error("accept without boundary");
    a_strobe_cause: assert property (vector_acknowledge_strobe |-> bnd)
        else $error("acknowledge without boundary");
    a_hold_sync: assert property (!$past(sys_rst) && !$past(sys_rst, 2)
        |-> holdSync == $past(holdRequest, 2)) else $error("hold not synchronised");
    c_trap: cover property (pushPc && acceptedSource == `CIP_SRC_TRAP);
    c_edge: cover property (branchValid && acceptedSource == `CIP_SRC_R75);
    c_vectored: cover property (vector_acknowledge_strobe);
endmodule
bind cip_cpu_interrupt_prioritizer cip_prioritizer_sva u_sva (.clk(clk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .holdRequest(holdRequest), .holdSync(holdSync),
    .dataBus(dataBus), .vector_acknowledge_strobe(vector_acknowledge_strobe),
    .pushPc(pushPc), .branchValid(branchValid), .branchAddress(branchAddress),
    .acceptedSource(acceptedSource));

/* test/cip_vector_source.sv */
// bus-vectored requester and restart opcode supplier
`timescale 1ns/1ps
module cip_vector_source (
    input wire clk,
    input wire raise,
    input wire [7:0] opcode,
    input wire vector_acknowledge_strobe,
    output reg bus_vectored_request,
    output wire [7:0] dataBus
);
    initial bus_vectored_request = 1'b0;
    // request holds until acknowledged
    always @(posedge clk) begin
        if (vector_acknowledge_strobe) begin
            bus_vectored_request <= 1'b0;
        end else if (raise) begin
            bus_vectored_request <= 1'b1;
        end
    end
    // opcode only in the acknowledge cycle, inverted otherwise
    assign dataBus = vector_acknowledge_strobe ? opcode : ~opcode;
endmodule

/* test/tb_top.sv */
// self-checking bench of the interrupt prioritizer
`timescale 1ns/1ps
`include "cip_map.vh"
module tb_top;
    reg clk = 1'b0, sysRst = 1'b1, rd = 1'b0, wr = 1'b0, trapReq = 1'b0, r75 = 1'b1;
    reg r65 = 1'b0, r55 = 1'b0, holdReq = 1'b0, raise = 1'b0;
    reg [3:0] adr = 4'h0;
    reg [31:0] wdat = 32'h0, got, rnd;
    reg [7:0] opc = 8'hC7;
    wire [31:0] rdat;
    wire waitReq, ack, busReq, pushPc, brValid, holdSync;
    wire [7:0] dBus;
    wire [15:0] brAddr;
    wire [2:0] src;
    integer fails = 0, n_tests = 0, seed = 32'hD0FA, ie = 0, msk = 7, ef = 0, armed = 1;
    integer saved = 0, fresh = 0, pend = 0, s, i, k;
    cip_cpu_interrupt_prioritizer u_dut (.clk(clk), .sys_rst(sysRst), .avs_address(adr),
        .avs_read(rd), .avs_write(wr), .avs_writedata(wdat), .avs_byteenable(4'hF),
        .avs_readdata(rdat), .avs_waitrequest(waitReq), .trapRequest(trapReq),
        .restart75Request(r75), .restart65Request(r65), .restart55Request(r55),
        .bus_vectored_request(busReq), .holdRequest(holdReq), .dataBus(dBus),
        .vector_acknowledge_strobe(ack), .holdSync(holdSync), .pushPc(pushPc),
        .branchValid(brValid), .branchAddress(brAddr), .acceptedSource(src));
    cip_vector_source u_src (.clk(clk), .raise(raise), .opcode(opc),
        .vector_acknowledge_strobe(ack), .bus_vectored_request(busReq), .dataBus(dBus));
    always #5 clk = ~clk;
    // random hold level each cycle
    always @(posedge clk) begin
        rnd = $random(seed);
        holdReq <= rnd[0];
    end
    // ====================
    task chk(input [31:0] g, input [31:0] x);
        begin
            n_tests = n_tests + 1;
            if (g !== x) begin
                fails = fails + 1;
                $display("wrong value at %0t: got %h expected %h", $time, g, x);
            end
        end
    endtask
    // one register access; read data taken at the edge that ends the wait
    task bus(input w, input [3:0] a, input [31:0] d);
        begin
            adr <= a;
            wdat <= d;
            wr <= w;
            rd <= !w;
            @(posedge clk);
            while (waitReq !== 1'b0) @(posedge clk);
            got = rdat;
            wr <= 1'b0;
            rd <= 1'b0;
            @(posedge clk);
        end
    endtask
    task st;
        begin
            bus(1'b0, `CIP_ADDR_STATUS, 32'h0);
            chk(got[6:0], {ef[0], r65, r55, fresh ? saved[0] : ie[0], msk[2:0]});
            fresh = 0;
        end
    endtask
    task pulse;
        begin
            r75 <= 1'b0;
            @(posedge clk);
            r75 <= 1'b1;
            ef = 1;
            repeat (4) @(posedge clk);
        end
    endtask
    function [15:0] vec(input integer c);
        case (c)
            1: vec = `CIP_VEC_TRAP;
            2: vec = `CIP_VEC_R75;
            3: vec = `CIP_VEC_R65;
            4: vec = `CIP_VEC_R55;
            default: vec = {10'h000, opc[5:3], 3'h0};
        endcase
    endfunction
    // predict the winner, request a boundary, compare
    task serve;
        begin
            s = 0;
            if (trapReq && armed) s = 1;
            else if (ie && ef && !msk[2]) s = 2;
            else if (ie && r65 && !msk[1]) s = 3;
            else if (ie && r55 && !msk[0]) s = 4;
            else if (ie && pend) s = 5;
            bus(1'b1, `CIP_ADDR_CTRL, 32'h4);
            for (i = 0; i < 12 && brValid !== 1'b1; i = i + 1) @(negedge clk);
            chk(i < 12, s != 0);
            if (s != 0) begin
                chk({src, brAddr}, {s[2:0], vec(s)});
                if (s == 1) begin
                    saved = ie;
                    fresh = 1;
                    armed = 0;
                end
                ie = 0;
                if (s == 2) ef = 0;
                if (s == 5) pend = 0;
            end
            @(posedge clk);
        end
    endtask
    task end_sim;
        begin
            $display("comparisons %0d mismatches %0d", n_tests, fails);
            if (fails == 0 && n_tests > 0) begin
                $display("Regression OK");
            end else begin
                $display("Regression broken");
            end
            $finish;
        end
    endtask
    // ====================
    initial begin
        #100000;
        fails = fails + 1;
        end_sim;
    end
    initial begin
        repeat (8) @(posedge clk);
        sysRst <= 1'b0;
        @(posedge clk);
        st;
        bus(1'b0, 4'h6, 32'h0);
        chk(got, 32'h0);
        pulse;
        st;
        bus(1'b1, `CIP_ADDR_CTRL, 32'h1);
        ie = 1;
        serve;
        bus(1'b1, `CIP_ADDR_MASK, 32'h18);
        msk = 0;
        ef = 0;
        st;
        pulse;
        bus(1'b1, `CIP_ADDR_CTRL, 32'h1);
        ie = 1;
        serve;
        st;
        pulse;
        bus(1'b1, `CIP_ADDR_CTRL, 32'h1);
        bus(1'b1, `CIP_ADDR_CTRL, 32'h2);
        ie = 0;
        serve;
        opc = {2'b11, rnd[5:3], 3'b111};
        trapReq <= 1'b1;
        r65 <= 1'b1;
        r55 <= 1'b1;
        raise <= 1'b1;
        @(posedge clk);
        raise <= 1'b0;
        pend = 1;
        pulse;
        for (k = 0; k < 5; k = k + 1) begin
            bus(1'b1, `CIP_ADDR_CTRL, 32'h1);
            ie = 1;
            serve;
            st;
            if (s == 3) r65 <= 1'b0;
            if (s == 4) r55 <= 1'b0;
            repeat (4) @(posedge clk);
        end
        trapReq <= 1'b0;
        armed = 1;
        bus(1'b1, `CIP_ADDR_MASK, 32'hF);
        msk = 7;
        trapReq <= 1'b1;
        repeat (4) @(posedge clk);
        serve;
        bus(1'b0, `CIP_ADDR_ACCEPT, 32'h0);
        chk(got[18:0], {s[2:0], vec(s)});
        end_sim;
    end
endmodule
